// File: logic/pups_pkg.sv
// pups_pkg: constants and types shared by the sequencer device end and the supervisor end.
// assumes one 40 MHz clock, CLK_IN, and a synchronous active-high reset, SYS_RST_IN.
package pups_pkg;
    localparam int CLK_HZ          = 40_000_000;
    localparam int CLK_PERIOD_PS   = 25_000;
    localparam int PARK_LEAD_NS    = 40_000;
    localparam int PARK_LEAD_CYC   = (PARK_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GLITCH_NS       = 150;
    localparam int GLITCH_CYC      = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int PLL_LOCK_CYC    = 64;
    localparam int FLASH_LOAD_CYC  = 256;
    localparam int PARK_DONE_CYC   = 200;
    localparam int SETTLE_CYC      = 32;
    localparam int REFSEL_24M      = 1;
    localparam int CNT_W           = 12;

    typedef enum logic [2:0] {
        PUPS_RESET  = 3'b000,
        PUPS_PLL    = 3'b001,
        PUPS_FLASH  = 3'b010,
        PUPS_READY  = 3'b011,
        PUPS_RUN    = 3'b100,
        PUPS_PARK   = 3'b101,
        PUPS_OFF    = 3'b110
    } pups_state_t;

    typedef enum logic [1:0] {
        PUPS_SUP_HOLD  = 2'b00,
        PUPS_SUP_WAIT  = 2'b01,
        PUPS_SUP_LIVE  = 2'b10,
        PUPS_SUP_DRAIN = 2'b11
    } pups_sup_t;
endpackage : pups_pkg

// File: logic/pups_if.sv
// pups_if: pins between the sequencer device and its supervisor/host.
// resolves the pull-up on the attention line from its enable: attn_line is high while attn_oe_n is set.
`timescale 1ns/1ps
`default_nettype none
interface pups_if;
    logic system_reset_low;
    logic fast_park_warning_low;
    logic projector_power_request;
    logic attn_out;
    logic attn_oe_n;
    logic attn_line;
    assign attn_line = attn_oe_n ? 1'b1 : attn_out;
    modport device (
        input  system_reset_low, fast_park_warning_low, projector_power_request, attn_line,
        output attn_out, attn_oe_n
    );
    modport host (
        output system_reset_low, fast_park_warning_low, projector_power_request,
        input  attn_line
    );
endinterface : pups_if
`default_nettype wire

// File: logic/pups_device.sv
// pups_device: power-up init and fast-park sequencer of the display controller.
// assumes pins from the supervisor are asynchronous to CLK_IN.
`timescale 1ns/1ps
`default_nettype none
module pups_device #(
    parameter int PLL_CYC   = pups_pkg::PLL_LOCK_CYC,
    parameter int FLASH_CYC = pups_pkg::FLASH_LOAD_CYC,
    parameter int PARK_CYC  = pups_pkg::PARK_DONE_CYC
) (
    input  wire logic CLK_IN,
    input  wire logic SYS_RST_IN,
    pups_if.device    PINS,
    input  wire logic REF_24M_SEL_IN,
    input  wire logic PLL_LOCKED_IN,
    output logic      PLL_ENABLE_OUT,
    output logic      PLL_DIV_24M_OUT,
    output logic      FLASH_LOAD_OUT,
    output logic      FLASH_IO_ACTIVE_OUT,
    output logic      LED_SELECT_0_OUT,
    output logic      LED_SELECT_0_OE_N_OUT,
    output logic      LED_SELECT_1_OUT,
    output logic      LED_SELECT_1_OE_N_OUT,
    output logic      FLASH_SEL_OE_N_OUT,
    output logic      BIDIR_OE_N_OUT,
    output logic      PROJECTING_OUT,
    output logic      MIRROR_PARK_OUT,
    output logic      INIT_DONE_OUT
);
    import pups_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] rst_sync;
    logic [1:0] park_sync;
    logic [1:0] pwr_sync;
    logic       rst_live;
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            rst_sync  <= 2'b00;
            park_sync <= 2'b11;
            pwr_sync  <= 2'b00;
        end else begin
            rst_sync  <= {rst_sync[0], PINS.system_reset_low};
            park_sync <= {park_sync[0], PINS.fast_park_warning_low};
            pwr_sync  <= {pwr_sync[0], PINS.projector_power_request};
        end
    end
    assign rst_live = rst_sync[1];

    // ****************************************
    // park warning glitch filter
    // ****************************************
    logic [CNT_W-1:0] flt_cnt;
    logic [CNT_W-1:0] next_flt_cnt;
    logic             park_ok;
    logic             next_park_ok;
    always_comb begin
        next_flt_cnt = '0;
        next_park_ok = park_ok;
        if (park_sync[1] != park_ok) begin
            next_flt_cnt = flt_cnt + 12'h001;
            if (flt_cnt == CNT_W'(GLITCH_CYC - 1)) begin
                next_park_ok = park_sync[1];
                next_flt_cnt = '0;
            end
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || !rst_live) begin
            flt_cnt <= '0;
            park_ok <= 1'b1;
        end else begin
            flt_cnt <= next_flt_cnt;
            park_ok <= next_park_ok;
        end
    end

    // ****************************************
    // init and park sequence
    // ****************************************
    pups_state_t      state;
    pups_state_t      next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    always_comb begin
        next_state = state;
        next_cnt   = cnt + 12'h001;
        unique case (state)
            PUPS_RESET: begin
                next_cnt   = '0;
                next_state = PUPS_PLL;
            end
            PUPS_PLL: begin
                if (PLL_LOCKED_IN && cnt >= CNT_W'(PLL_CYC)) begin
                    next_state = PUPS_FLASH;
                    next_cnt   = '0;
                end
            end
            PUPS_FLASH: begin
                if (cnt == CNT_W'(FLASH_CYC - 1)) begin
                    next_state = PUPS_READY;
                    next_cnt   = '0;
                end
            end
            PUPS_READY: begin
                next_cnt = '0;
                if (pwr_sync[1]) begin
                    next_state = PUPS_RUN;
                end
            end
            PUPS_RUN: begin
                next_cnt = '0;
                if (!park_ok || !pwr_sync[1]) begin
                    next_state = PUPS_PARK;
                end
            end
            PUPS_PARK: begin
                if (cnt == CNT_W'(PARK_CYC - 1)) begin
                    next_state = PUPS_OFF;
                    next_cnt   = '0;
                end
            end
            PUPS_OFF: begin
                next_cnt = '0;
                if (pwr_sync[1] && park_ok) begin
                    next_state = PUPS_RUN;
                end
            end
            default: begin
                next_state = PUPS_RESET;
                next_cnt   = '0;
            end
        endcase
        if (state == PUPS_READY && !park_ok) begin
            next_state = PUPS_OFF;
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || !rst_live) begin
            state <= PUPS_RESET;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ****************************************
    // registered pin drive
    // ****************************************
    logic in_reset;
    logic initing;
    assign in_reset = (state == PUPS_RESET);
    assign initing  = (state == PUPS_PLL) || (state == PUPS_FLASH);
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || !rst_live) begin
            PINS.attn_out         <= 1'b0;
            PINS.attn_oe_n        <= 1'b1;
            PLL_ENABLE_OUT        <= 1'b0;
            PLL_DIV_24M_OUT       <= 1'b0;
            FLASH_LOAD_OUT        <= 1'b0;
            FLASH_IO_ACTIVE_OUT   <= 1'b0;
            LED_SELECT_0_OUT      <= 1'b0;
            LED_SELECT_0_OE_N_OUT <= 1'b1;
            LED_SELECT_1_OUT      <= 1'b0;
            LED_SELECT_1_OE_N_OUT <= 1'b1;
            FLASH_SEL_OE_N_OUT    <= 1'b1;
            BIDIR_OE_N_OUT        <= 1'b1;
            PROJECTING_OUT        <= 1'b0;
            MIRROR_PARK_OUT       <= 1'b0;
            INIT_DONE_OUT         <= 1'b0;
        end else begin
            PINS.attn_out         <= initing || in_reset;
            PINS.attn_oe_n        <= 1'b0;
            PLL_ENABLE_OUT        <= 1'b1;
            PLL_DIV_24M_OUT       <= (REF_24M_SEL_IN == REFSEL_24M[0]);
            FLASH_LOAD_OUT        <= (next_state == PUPS_FLASH);
            FLASH_IO_ACTIVE_OUT   <= 1'b1;
            LED_SELECT_0_OUT      <= (next_state == PUPS_RUN);
            LED_SELECT_0_OE_N_OUT <= 1'b0;
            LED_SELECT_1_OUT      <= (next_state == PUPS_RUN);
            LED_SELECT_1_OE_N_OUT <= 1'b0;
            FLASH_SEL_OE_N_OUT    <= 1'b0;
            BIDIR_OE_N_OUT        <= 1'b0;
            PROJECTING_OUT        <= (next_state == PUPS_RUN);
            MIRROR_PARK_OUT       <= (next_state == PUPS_PARK);
            INIT_DONE_OUT         <= !(initing || in_reset);
        end
    end
endmodule : pups_device
`default_nettype wire

// File: logic/pups_host.sv
// pups_host: supervisor and host end; sequences reset, park warning and power request.
// assumes supply-good and clock-stable come from logic on CLK_IN.
`timescale 1ns/1ps
`default_nettype none
module pups_host (
    input  wire logic CLK_IN,
    input  wire logic SYS_RST_IN,
    pups_if.host      PINS,
    input  wire logic SUPPLY_GOOD_IN,
    input  wire logic CLOCK_STABLE_IN,
    input  wire logic SUPPLY_FAIL_SOON_IN,
    input  wire logic POWER_ON_IN,
    output logic      CMD_ALLOWED_OUT,
    output logic      SAFE_TO_DROP_OUT
);
    import pups_pkg::*;

    pups_sup_t        state;
    pups_sup_t        next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [1:0]       attn_sync;
    always_comb begin
        next_state = state;
        next_cnt   = '0;
        unique case (state)
            PUPS_SUP_HOLD: begin
                if (SUPPLY_GOOD_IN && CLOCK_STABLE_IN && !SUPPLY_FAIL_SOON_IN) begin
                    next_state = PUPS_SUP_WAIT;
                end
            end
            PUPS_SUP_WAIT: begin
                if (!attn_sync[1]) begin
                    next_state = PUPS_SUP_LIVE;
                end
                if (SUPPLY_FAIL_SOON_IN) begin
                    next_state = PUPS_SUP_DRAIN;
                end
            end
            PUPS_SUP_LIVE: begin
                if (SUPPLY_FAIL_SOON_IN) begin
                    next_state = PUPS_SUP_DRAIN;
                end
            end
            PUPS_SUP_DRAIN: begin
                next_cnt = cnt + 12'h001;
                if (cnt == CNT_W'(PARK_LEAD_CYC - 1)) begin
                    next_state = PUPS_SUP_HOLD;
                    next_cnt   = '0;
                end
            end
        endcase
    end
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state     <= PUPS_SUP_HOLD;
            cnt       <= '0;
            attn_sync <= 2'b11;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            attn_sync <= {attn_sync[0], PINS.attn_line};
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            PINS.system_reset_low        <= 1'b0;
            PINS.fast_park_warning_low   <= 1'b1;
            PINS.projector_power_request <= 1'b0;
            CMD_ALLOWED_OUT              <= 1'b0;
            SAFE_TO_DROP_OUT             <= 1'b1;
        end else begin
            PINS.system_reset_low        <= (next_state != PUPS_SUP_HOLD);
            PINS.fast_park_warning_low   <= (next_state != PUPS_SUP_DRAIN);
            PINS.projector_power_request <= POWER_ON_IN && (next_state == PUPS_SUP_LIVE);
            CMD_ALLOWED_OUT              <= (next_state == PUPS_SUP_LIVE);
            SAFE_TO_DROP_OUT             <= (next_state == PUPS_SUP_HOLD);
        end
    end
endmodule : pups_host
`default_nettype wire

// File: test/pups_props.sv
// pups_props: assertions on the pins between sequencer and supervisor.
// assumes it sits beside the pups_if link, sampled on CLK_IN.
`timescale 1ns/1ps
`default_nettype none
module pups_props (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic system_reset_low,
    input wire logic fast_park_warning_low,
    input wire logic projector_power_request,
    input wire logic attn_out,
    input wire logic attn_oe_n,
    input wire logic attn_line
);
    import pups_pkg::*;

    // ****************************************
    // park lead-time counter
    // ****************************************
    logic [CNT_W-1:0] lead_cnt;
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || fast_park_warning_low) begin
            lead_cnt <= '0;
        end else if (lead_cnt != '1) begin
            lead_cnt <= lead_cnt + 12'h001;
        end
    end
    // ****************************************
    // pin relations
    // ****************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence s_release; $rose(system_reset_low); endsequence
    sequence s_done; ##[12:150] $fell(attn_line); endsequence
    a_release_drives_high: assert property (s_release |-> ##[1:6] (!attn_oe_n && attn_out))
        else $error("attention not driven high");
    a_attn_stays_high: assert property (s_release |-> attn_line [*8])
        else $error("attention dropped early");
    a_init_ends_low: assert property (s_release |-> s_done)
        else $error("init did not finish");
    a_attn_fall_driven: assert property ($fell(attn_line) |-> system_reset_low && !attn_oe_n)
        else $error("attention fell undriven");
    a_reset_frees_pin: assert property (!system_reset_low [*6] |-> attn_oe_n)
        else $error("attention driven in reset");
    a_release_needs_warn: assert property (s_release |-> fast_park_warning_low)
        else $error("released with warning low");
    a_warn_keeps_reset: assert property ($fell(fast_park_warning_low) |-> system_reset_low [*8])
        else $error("reset fell during park");
    a_release_synced: assert property (s_release |-> attn_oe_n ##1 attn_oe_n)
        else $error("release acted unsynchronised");
    a_park_lead_kept: assert property ($fell(system_reset_low) |-> $past(fast_park_warning_low) || lead_cnt >= CNT_W'(PARK_LEAD_CYC))
        else $error("reset fell before park lead time");
endmodule : pups_props
`default_nettype wire

// File: test/power_up_init_park_sequencer_test.sv
// power_up_init_park_sequencer_test: both ends joined, a second device fed glitches.
// assumes pups_pkg, pups_if and both design ends compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD %0t %s", $time, m); end end
`define WAIT(c) n = 0; while ((c) !== 1'b1 && n < 3000) begin tick(1); n++; end \
    if (n >= 3000) miscompares++;
module power_up_init_park_sequencer_test;
    import pups_pkg::*;
    typedef struct {logic ref24; logic fast; logic div; logic safe;} pups_row_t;
    // ****************************************
    // wiring
    // ****************************************
    logic clk = 1'b0;
    logic rst, good, stable, fail, pwr, ref_sel, lock, lock2, cmd, safe;
    logic pll_en, div24, fload, fact, led0, led0_oe, led1, led1_oe, fsel_oe, bidir_oe;
    logic proj, park, done, pll_en2, park2, done2;
    int   miscompares = 0;
    int   compares = 0;
    int   i, n;
    pups_row_t rows [2] = '{'{1'b1, 1'b1, 1'b1, 1'b1}, '{1'b0, 1'b0, 1'b0, 1'b0}};
    pups_if link ();
    pups_if glitch ();
    pups_device #(.PLL_CYC(4), .FLASH_CYC(8), .PARK_CYC(8)) pups_device_inst (
        .CLK_IN(clk), .SYS_RST_IN(rst), .PINS(link.device), .REF_24M_SEL_IN(ref_sel),
        .PLL_LOCKED_IN(lock), .PLL_ENABLE_OUT(pll_en), .PLL_DIV_24M_OUT(div24),
        .FLASH_LOAD_OUT(fload), .FLASH_IO_ACTIVE_OUT(fact), .LED_SELECT_0_OUT(led0),
        .LED_SELECT_0_OE_N_OUT(led0_oe), .LED_SELECT_1_OUT(led1),
        .LED_SELECT_1_OE_N_OUT(led1_oe), .FLASH_SEL_OE_N_OUT(fsel_oe),
        .BIDIR_OE_N_OUT(bidir_oe), .PROJECTING_OUT(proj), .MIRROR_PARK_OUT(park),
        .INIT_DONE_OUT(done));
    pups_device #(.PLL_CYC(4), .FLASH_CYC(8), .PARK_CYC(8)) pups_device_glitch_inst (
        .CLK_IN(clk), .SYS_RST_IN(rst), .PINS(glitch.device), .REF_24M_SEL_IN(ref_sel),
        .PLL_LOCKED_IN(lock2), .PLL_ENABLE_OUT(pll_en2), .PLL_DIV_24M_OUT(),
        .FLASH_LOAD_OUT(), .FLASH_IO_ACTIVE_OUT(), .LED_SELECT_0_OUT(),
        .LED_SELECT_0_OE_N_OUT(), .LED_SELECT_1_OUT(), .LED_SELECT_1_OE_N_OUT(),
        .FLASH_SEL_OE_N_OUT(), .BIDIR_OE_N_OUT(), .PROJECTING_OUT(),
        .MIRROR_PARK_OUT(park2), .INIT_DONE_OUT(done2));
    pups_host pups_host_inst (
        .CLK_IN(clk), .SYS_RST_IN(rst), .PINS(link.host), .SUPPLY_GOOD_IN(good),
        .CLOCK_STABLE_IN(stable), .SUPPLY_FAIL_SOON_IN(fail), .POWER_ON_IN(pwr),
        .CMD_ALLOWED_OUT(cmd), .SAFE_TO_DROP_OUT(safe));
    pups_props pups_props_inst (
        .CLK_IN(clk), .SYS_RST_IN(rst), .system_reset_low(link.system_reset_low),
        .fast_park_warning_low(link.fast_park_warning_low),
        .projector_power_request(link.projector_power_request),
        .attn_out(link.attn_out), .attn_oe_n(link.attn_oe_n), .attn_line(link.attn_line));
    // ****************************************
    // stimulus and checks
    // ****************************************
    task tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial forever #12.5 clk = ~clk;
    // pll model locks half a cycle after enable
    always @(negedge clk) begin
        lock <= pll_en;
        lock2 <= pll_en2;
        if (fload === 1'b1) `CHK(lock, 1'b1, "flash load before lock")
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    initial begin
        {rst, good, stable, fail, pwr, ref_sel} = 6'h20;
        glitch.system_reset_low = 1'b0;
        glitch.fast_park_warning_low = 1'b1;
        glitch.projector_power_request = 1'b0;
        tick(8);
        `CHK(led0_oe & led1_oe & fsel_oe & bidir_oe, 1'b1, "pins driven in reset")
        `CHK(proj | park | done | fact | pll_en, 1'b0, "outputs active in reset")
        `CHK(link.attn_oe_n, 1'b1, "attention driven in reset")
        rst = 1'b0;
        glitch.system_reset_low = 1'b1;
        glitch.projector_power_request = 1'b1;
        tick(4);
        `CHK(link.system_reset_low, 1'b0, "released without supplies")
        good = 1'b1;
        tick(4);
        `CHK(link.system_reset_low, 1'b0, "released without stable clock")
        for (i = 0; i < 2; i++) begin
            ref_sel = rows[i].ref24;
            good = 1'b1;
            stable = 1'b1;
            `WAIT(done)
            `CHK(div24, rows[i].div, "reference select")
            `CHK(link.attn_line, 1'b0, "attention still high")
            tick(5);
            `CHK(cmd, 1'b1, "commands not allowed")
            pwr = 1'b1;
            tick(10);
            `CHK(proj & led0 & led1, 1'b1, "not projecting")
            `CHK(led0_oe | led1_oe | fsel_oe | bidir_oe | !fact, 1'b0, "pins not active")
            if (rows[i].fast) fail = 1'b1;
            else pwr = 1'b0;
            `WAIT(park)
            `CHK(park, 1'b1, "no park")
            tick(PARK_LEAD_CYC + 20);
            `CHK(proj, 1'b0, "still projecting")
            `CHK(safe, rows[i].safe, "drop indication")
            `CHK(link.system_reset_low, !rows[i].fast, "reset after drain")
            `CHK(fsel_oe & bidir_oe, rows[i].fast, "pins after drain")
            fail = 1'b0;
            pwr = 1'b0;
        end
        `CHK(done2, 1'b1, "second device not ready")
        glitch.fast_park_warning_low = 1'b0;
        tick(GLITCH_CYC - 1);
        glitch.fast_park_warning_low = 1'b1;
        tick(12);
        `CHK(park2, 1'b0, "glitch caused park")
        glitch.fast_park_warning_low = 1'b0;
        tick(GLITCH_CYC + 8);
        `CHK(park2, 1'b1, "warning missed")
        stop_test();
    end
endmodule : power_up_init_park_sequencer_test
`default_nettype wire
